// *** verilog/mpmc_pkg.sv ***
/*
 Constants and carrier types for the power-mode and pin-control sequencer.
 Assumes the instruction core presents an execute strobe with the raw opcode, and bus requests.
*/
package mpmc_pkg;
  localparam logic [7:0] MPMC_OP_IDLE = 8'h01;
  localparam logic [7:0] MPMC_OP_STANDBY = 8'h63;
  localparam logic [7:0] MPMC_OP_CLKOUT = 8'h75;
  localparam logic [11:0] MPMC_VEC_RESET = 12'h000;
  localparam logic [11:0] MPMC_VEC_INT = 12'h003;
  localparam int MPMC_CLK_HZ = 25000000;
  localparam int MPMC_OSC_START_US = 5000;
  localparam int MPMC_OSC_START_CYC = MPMC_OSC_START_US * (MPMC_CLK_HZ / 1000000);
  localparam int MPMC_STAB_MCYC = 3;
  localparam int MPMC_MCYC_STATES = 5;
  localparam int MPMC_ROM_WORDS = 2048;
  localparam int MPMC_CNT_W = 20;
  localparam int MPMC_PH_W = 3;
  localparam logic [2:0] MPMC_PH_ALE = 3'h0;
  localparam logic [2:0] MPMC_PH_STRB_FIRST = 3'h1;
  localparam logic [2:0] MPMC_PH_STRB_LAST = 3'h3;

  typedef enum logic [1:0] {
    MPMC_BK_FETCH = 2'h0,
    MPMC_BK_READ = 2'h1,
    MPMC_BK_WRITE = 2'h2,
    MPMC_BK_EXP = 2'h3
  } mpmc_bus_kind_t;

  // For expander transfers wdata[3:0] is the command nibble, wdata[7:4] the data, addr[0] set means write.
  typedef struct packed {
    logic valid;
    mpmc_bus_kind_t kind;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mpmc_bus_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } mpmc_bus_rsp_t;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
  } mpmc_resume_t;
endpackage

// *** verilog/mpmc_mcycle.sv ***
/*
 Machine-cycle phase counter for the sequencer.
 Assumes en_i is low whenever the core clock is stopped, so the phase freezes.
*/
`timescale 1ns/10ps
`default_nettype none
module mpmc_mcycle #(
  parameter int STATES = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic en_i,
  // Phase
  output logic [2:0] phase_o,
  output logic cycle_end_o
);
  import mpmc_pkg::*;

  localparam logic [2:0] LAST = 3'(STATES - 1);
  logic [2:0] phase;
  logic [2:0] next_phase;

  assign cycle_end_o = en_i && (phase == LAST);
  assign phase_o = phase;

  always_comb begin
    next_phase = phase;
    if (en_i) begin
      next_phase = (phase == LAST) ? MPMC_PH_ALE : phase + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase <= MPMC_PH_ALE;
    end else begin
      phase <= next_phase;
    end
  end

  AST_PHASE_FROZEN: assert property (@(posedge clk_i) disable iff (reset_i)
    !en_i |=> phase == $past(phase)) else $error("Phase moved while frozen.");
endmodule // mpmc_mcycle
`default_nettype wire

// *** verilog/mpmc_seq.sv ***
/*
 Power-mode sequencer and pin control: idle, standby, stop, ROM verify,
 single step and the external bus strobes.
 Assumes the core freezes while core_run_o is low and reloads its PC from resume_o.
*/
`timescale 1ns/10ps
`default_nettype none
module mpmc_seq #(
  parameter int OSC_START_CYC = mpmc_pkg::MPMC_OSC_START_CYC,
  parameter int ROM_WORDS = mpmc_pkg::MPMC_ROM_WORDS,
  parameter int MCYC_STATES = mpmc_pkg::MPMC_MCYC_STATES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Mode pins
  input wire logic reset_pin_n_i,
  input wire logic stop_n_i,
  input wire logic external_fetch_force_i,
  input wire logic verify_level_i,
  input wire logic int_n_i,
  input wire logic single_step_n_i,
  input wire logic test_input_zero_i,
  input wire logic test_input_one_i,
  // Bus pins
  input wire logic [7:0] data_bus_i,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_o,
  input wire logic [3:0] port2_low_nibble_i,
  output logic [3:0] port2_low_nibble_o,
  output logic port2_low_nibble_oe_o,
  output logic test_input_zero_o,
  output logic test_input_zero_oe_o,
  output logic ale_o,
  output logic program_store_strobe_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic expander_strobe_n_o,
  // Core side
  input wire logic op_exec_i,
  input wire logic [7:0] opcode_i,
  input wire logic [11:0] next_pc_i,
  input wire logic int_enable_i,
  input wire logic count_sel_i,
  input wire logic bus_latch_en_i,
  input wire logic [7:0] bus_latch_i,
  input wire logic port2_drive_i,
  input wire logic [3:0] port2_latch_i,
  input wire mpmc_pkg::mpmc_bus_req_t bus_req_i,
  output logic bus_take_o,
  output mpmc_pkg::mpmc_bus_rsp_t bus_rsp_o,
  output mpmc_pkg::mpmc_resume_t resume_o,
  output logic core_run_o,
  output logic osc_en_o,
  output logic irq_start_o,
  output logic test0_o,
  output logic test1_o,
  output logic count_pulse_o,
  // ROM port
  output logic [10:0] rom_addr_o,
  input wire logic [7:0] rom_data_i
);
  import mpmc_pkg::*;

  typedef enum logic [8:0] {
    S_RUN = 9'h001, S_IDLE = 9'h002, S_STANDBY = 9'h004,
    S_WAKE_OSC = 9'h008, S_WAKE_STAB = 9'h010, S_STOP = 9'h020,
    S_VERIFY = 9'h040, S_STEP = 9'h080, S_HELD = 9'h100
  } mpmc_state_t;

  localparam logic [MPMC_CNT_W-1:0] OSC_LAST = MPMC_CNT_W'(OSC_START_CYC - 1);
  localparam logic [MPMC_CNT_W-1:0] STAB_LAST = MPMC_CNT_W'(MPMC_STAB_MCYC - 1);

  function automatic logic is_external(input logic force_ext, input logic [11:0] addr);
    return force_ext || (32'(addr) >= ROM_WORDS);
  endfunction

  mpmc_state_t st_q, next_st;
  logic [MPMC_CNT_W-1:0] cnt_q, next_cnt;
  logic wake_int_q, next_wake_int;
  logic clkout_q, next_clkout;
  logic t0clk_q, next_t0clk;
  logic rst_prev_q, tone_prev_q;
  logic [7:0] vdata_q, next_vdata;
  logic [10:0] rom_addr_q, next_rom_addr;
  mpmc_bus_req_t cur_q, next_cur;
  mpmc_bus_rsp_t rsp_q, next_rsp;
  mpmc_resume_t res_q, next_res;
  logic [2:0] phase;
  logic cycle_end, running, strobe_on, ext_fetch;
  logic [10:0] verify_addr_in;
  logic [11:0] wake_addr;

  assign running = (st_q == S_RUN);
  assign verify_addr_in = {port2_low_nibble_i[2:0], data_bus_i};
  assign wake_addr = int_enable_i ? MPMC_VEC_INT : next_pc_i;

  // The phase counter also runs during stabilisation so that it can count machine cycles.
  mpmc_mcycle #(.STATES(MCYC_STATES)) u_mcycle (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .en_i(running || st_q == S_WAKE_STAB),
    .phase_o(phase),
    .cycle_end_o(cycle_end)
  );

  always_comb begin
    next_st = st_q;
    next_cnt = cnt_q;
    next_wake_int = wake_int_q;
    next_clkout = clkout_q;
    next_t0clk = clkout_q ? ~t0clk_q : 1'b0;
    next_vdata = vdata_q;
    next_rom_addr = rom_addr_q;
    next_cur = cur_q;
    next_rsp = '{done: 1'b0, rdata: rsp_q.rdata};
    next_res = '{valid: 1'b0, addr: res_q.addr};
    unique case (st_q)
      S_RUN: begin
        if (op_exec_i && opcode_i == MPMC_OP_CLKOUT) begin
          next_clkout = 1'b1;
        end
        if (phase == MPMC_PH_STRB_LAST && cur_q.valid) begin
          next_rsp.done = 1'b1;
          if (cur_q.kind == MPMC_BK_EXP) begin
            next_rsp.rdata = {4'h0, port2_low_nibble_i};
          end else if (cur_q.kind == MPMC_BK_FETCH && !ext_fetch) begin
            next_rsp.rdata = rom_data_i;
          end else begin
            next_rsp.rdata = data_bus_i;
          end
        end
        if (cycle_end) begin
          next_cur = bus_req_i;
          next_rom_addr = bus_req_i.addr[10:0];
        end
        if (!reset_pin_n_i) begin
          next_st = S_HELD;
        end else if (op_exec_i && opcode_i == MPMC_OP_IDLE) begin
          next_st = S_IDLE;
        end else if (op_exec_i && opcode_i == MPMC_OP_STANDBY) begin
          next_st = S_STANDBY;
        end else if (!single_step_n_i && cycle_end && cur_q.valid && cur_q.kind == MPMC_BK_FETCH) begin
          next_st = S_STEP;
        end
      end
      S_IDLE: begin
        if (!reset_pin_n_i) begin
          next_st = S_HELD;
        end else if (!int_n_i) begin
          next_st = S_RUN;
          next_res = '{valid: 1'b1, addr: wake_addr};
        end
      end
      S_STANDBY: begin
        if (!reset_pin_n_i || !int_n_i) begin
          next_st = S_WAKE_OSC;
          next_cnt = '0;
          next_wake_int = reset_pin_n_i;
        end
      end
      S_WAKE_OSC: begin
        next_cnt = cnt_q + 1'b1;
        if (cnt_q == OSC_LAST) begin
          next_st = S_WAKE_STAB;
          next_cnt = '0;
        end
      end
      S_WAKE_STAB: begin
        if (cycle_end) begin
          next_cnt = cnt_q + 1'b1;
          if (cnt_q == STAB_LAST) begin
            if (wake_int_q && reset_pin_n_i) begin
              next_st = S_RUN;
              next_res = '{valid: 1'b1, addr: wake_addr};
            end else begin
              next_st = S_HELD;
            end
          end
        end
      end
      S_STOP: begin
        if (stop_n_i && reset_pin_n_i) begin
          next_st = S_RUN;
          next_res = '{valid: 1'b1, addr: MPMC_VEC_RESET};
        end
      end
      S_VERIFY: begin
        if (reset_pin_n_i && !rst_prev_q) begin
          next_rom_addr = verify_addr_in;
        end
        next_vdata = rom_data_i;
        if (!reset_pin_n_i && !verify_level_i) begin
          next_st = S_HELD;
        end
      end
      S_STEP: begin
        if (!reset_pin_n_i) begin
          next_st = S_HELD;
        end else if (single_step_n_i) begin
          next_st = S_RUN;
        end
      end
      S_HELD: begin
        next_clkout = 1'b0;
        if (!stop_n_i) begin
          next_st = S_STOP;
        end else if (verify_level_i) begin
          next_st = S_VERIFY;
        end else if (reset_pin_n_i) begin
          next_st = S_RUN;
          next_res = '{valid: 1'b1, addr: MPMC_VEC_RESET};
        end
      end
    endcase
    if (next_st != S_RUN) begin
      next_cur.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= S_HELD;
      cnt_q <= '0;
      wake_int_q <= 1'b0;
      clkout_q <= 1'b0;
      t0clk_q <= 1'b0;
      rst_prev_q <= 1'b0;
      tone_prev_q <= 1'b0;
      vdata_q <= 8'h00;
      rom_addr_q <= 11'h000;
      cur_q <= '0;
      rsp_q <= '0;
      res_q <= '0;
    end else begin
      st_q <= next_st;
      cnt_q <= next_cnt;
      wake_int_q <= next_wake_int;
      clkout_q <= next_clkout;
      t0clk_q <= next_t0clk;
      rst_prev_q <= reset_pin_n_i;
      tone_prev_q <= test_input_one_i;
      vdata_q <= next_vdata;
      rom_addr_q <= next_rom_addr;
      cur_q <= next_cur;
      rsp_q <= next_rsp;
      res_q <= next_res;
    end
  end

  assign ext_fetch = is_external(external_fetch_force_i, cur_q.addr);
  assign strobe_on = running && cur_q.valid && phase >= MPMC_PH_STRB_FIRST && phase <= MPMC_PH_STRB_LAST;

  always_comb begin
    data_bus_o = bus_latch_i;
    data_bus_oe_o = bus_latch_en_i && running;
    port2_low_nibble_o = port2_latch_i;
    port2_low_nibble_oe_o = port2_drive_i && running;
    if (st_q == S_VERIFY) begin
      data_bus_o = vdata_q;
      data_bus_oe_o = reset_pin_n_i && rst_prev_q;
    end else if (running && cur_q.valid) begin
      unique case (cur_q.kind)
        MPMC_BK_FETCH: begin
          if (ext_fetch) begin
            port2_low_nibble_o = cur_q.addr[11:8];
            port2_low_nibble_oe_o = 1'b1;
            data_bus_o = cur_q.addr[7:0];
            data_bus_oe_o = (phase == MPMC_PH_ALE);
          end
        end
        MPMC_BK_EXP: begin
          port2_low_nibble_o = (phase == MPMC_PH_ALE) ? cur_q.wdata[3:0] : cur_q.wdata[7:4];
          port2_low_nibble_oe_o = (phase == MPMC_PH_ALE) || (strobe_on && cur_q.addr[0]);
        end
        default: begin
          data_bus_o = (phase == MPMC_PH_ALE) ? cur_q.addr[7:0] : cur_q.wdata;
          data_bus_oe_o = (phase == MPMC_PH_ALE) || (strobe_on && cur_q.kind == MPMC_BK_WRITE);
        end
      endcase
    end
  end

  assign ale_o = (running && phase == MPMC_PH_ALE) || st_q == S_STEP;
  assign program_store_strobe_n_o = !(strobe_on && cur_q.kind == MPMC_BK_FETCH && ext_fetch);
  assign rd_n_o = !(strobe_on && cur_q.kind == MPMC_BK_READ);
  assign wr_n_o = !(strobe_on && cur_q.kind == MPMC_BK_WRITE);
  assign expander_strobe_n_o = !(strobe_on && cur_q.kind == MPMC_BK_EXP);
  assign bus_take_o = cycle_end && running;
  assign bus_rsp_o = rsp_q;
  assign resume_o = res_q;
  assign rom_addr_o = rom_addr_q;
  assign core_run_o = running;
  assign osc_en_o = !(st_q == S_STANDBY || st_q == S_STOP);
  assign irq_start_o = running && int_enable_i && !int_n_i;
  assign test_input_zero_o = t0clk_q;
  assign test_input_zero_oe_o = clkout_q;
  assign test0_o = clkout_q ? 1'b0 : test_input_zero_i;
  assign test1_o = test_input_one_i;
  assign count_pulse_o = running && count_sel_i && tone_prev_q && !test_input_one_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_IDLE_GATED: assert property (st_q == S_IDLE |-> !core_run_o && osc_en_o && !ale_o)
    else $error("Idle state left core running or oscillator off.");
  AST_IDLE_INT_WAKE: assert property (st_q == S_IDLE && reset_pin_n_i && !int_n_i |=> core_run_o
    && resume_o.valid && resume_o.addr == ($past(int_enable_i) ? MPMC_VEC_INT : $past(next_pc_i)))
    else $error("Interrupt wake chose the wrong address.");
  AST_RESET_RESTART: assert property (st_q == S_HELD && stop_n_i && !verify_level_i && reset_pin_n_i
    |=> resume_o.valid && resume_o.addr == MPMC_VEC_RESET ##1 !resume_o.valid)
    else $error("Reset release did not restart at zero.");
  AST_STOP_OSC: assert property (st_q == S_STOP |-> !osc_en_o && !core_run_o)
    else $error("Oscillator running in stop state.");
  AST_STOP_EXIT: assert property (st_q == S_STOP && stop_n_i && reset_pin_n_i |=> core_run_o
    && resume_o.addr == MPMC_VEC_RESET) else $error("Stop exit did not start at zero.");
  AST_STANDBY_ENTRY: assert property (running && reset_pin_n_i && op_exec_i && opcode_i == MPMC_OP_STANDBY
    |=> !osc_en_o && !core_run_o) else $error("Standby did not stop the oscillator.");
  AST_STANDBY_START_WAIT: assert property ($fell(st_q == S_WAKE_OSC) |-> $past(cnt_q) == OSC_LAST)
    else $error("Oscillator start-up wait has the wrong length.");
  AST_STRB_QUIET: assert property (!core_run_o && st_q != S_STEP |-> !ale_o && rd_n_o && wr_n_o
    && program_store_strobe_n_o && expander_strobe_n_o) else $error("Strobe active while halted.");
  AST_PSTROBE_FETCH: assert property (!program_store_strobe_n_o |-> cur_q.kind == MPMC_BK_FETCH
    && rd_n_o && wr_n_o) else $error("Program strobe outside a fetch.");
  AST_EXT_FORCE: assert property (strobe_on && cur_q.kind == MPMC_BK_FETCH && external_fetch_force_i
    |-> !program_store_strobe_n_o) else $error("Forced external fetch without program strobe.");
  AST_ALE_SINGLE: assert property (ale_o && core_run_o |=> !ale_o)
    else $error("Address strobe longer than one phase.");
  AST_VERIFY_LATCH: assert property (st_q == S_VERIFY && $rose(reset_pin_n_i) && !$past(reset_i)
    |=> rom_addr_o == $past(verify_addr_in) && data_bus_oe_o) else $error("Verify address not latched.");
  AST_IRQ_GATE: assert property (irq_start_o |-> int_enable_i && !int_n_i && core_run_o)
    else $error("Interrupt started while disabled.");
  AST_STEP_ALE: assert property (st_q == S_STEP |-> ale_o && !core_run_o)
    else $error("Single step pause without address strobe held.");

  COV_IDLE_INT: cover property (st_q == S_IDLE ##1 running && resume_o.valid);
  COV_STANDBY_WAKE: cover property ($fell(st_q == S_WAKE_STAB) && running);
  COV_VERIFY_READ: cover property (st_q == S_VERIFY && data_bus_oe_o);
  COV_STOP_EXIT: cover property (st_q == S_STOP ##1 running);
endmodule // mpmc_seq
`default_nettype wire

// *** tb/mpmc_ext_mem.sv ***
/*
 External program and data memory seen from the sequencer's strobes.
 Assumes the bench routes bus_o onto the data bus pins and owns the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mpmc_ext_mem (
  // Clock
  input wire logic clk_i,
  // Device strobes
  input wire logic ale_i,
  input wire logic pstrb_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] bus_i,
  // Drive back
  output logic [7:0] bus_o
);
  logic [7:0] mem [256];
  logic [7:0] addr;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    addr = 8'h00;
    bus_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (ale_i) addr <= bus_i;
    if (!wr_n_i) mem[addr] <= bus_i;
    // read drive
    // A released bus shows a changing pattern so a stale value never passes.
    if (!rd_n_i || !pstrb_n_i) bus_o <= mem[addr];
    else bus_o <= ~bus_o;
  end
endmodule // mpmc_ext_mem
`default_nettype wire

// *** tb/mpmc_seq_bench.sv ***
/*
 Self-checking bench for the power-mode and pin-control sequencer.
 Assumes the package constants and a short oscillator start count.
*/
`timescale 1ns/10ps
`default_nettype none
module mpmc_seq_bench;
  import mpmc_pkg::*;
  localparam int OSC = 20;
  logic clk, rst, rpin_n, stop_n, fext, vlev, int_n, tin0, tin1, opx, inten, csel, ble, vdrive, sstep_n;
  logic dboe, p2oe, t0o, t0oe, ale, pstrb_n, rd_n, wr_n, exp_n, take, run, osc, irq, t0s, t1s, cntp;
  logic [7:0] opc, blat, vbus, mem_bus, dbo, dbi, rom_d;
  logic [11:0] npc;
  logic [3:0] p2i, p2o;
  logic [10:0] rom_a;
  mpmc_bus_req_t req;
  mpmc_bus_rsp_t rsp;
  mpmc_resume_t res;
  int errors, compares;

  function automatic logic [7:0] rom_of(input logic [10:0] a);
    return a[7:0] + {5'h00, a[10:8]};
  endfunction
  assign rom_d = rom_of(rom_a);
  assign dbi = vdrive ? vbus : mem_bus;

  mpmc_seq #(.OSC_START_CYC(OSC)) u_mpmc_seq (
    .clk_i(clk), .reset_i(rst), .reset_pin_n_i(rpin_n), .stop_n_i(stop_n),
    .external_fetch_force_i(fext), .verify_level_i(vlev), .int_n_i(int_n), .single_step_n_i(sstep_n),
    .test_input_zero_i(tin0), .test_input_one_i(tin1), .data_bus_i(dbi), .data_bus_o(dbo),
    .data_bus_oe_o(dboe), .port2_low_nibble_i(p2i), .port2_low_nibble_o(p2o),
    .port2_low_nibble_oe_o(p2oe), .test_input_zero_o(t0o), .test_input_zero_oe_o(t0oe),
    .ale_o(ale), .program_store_strobe_n_o(pstrb_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .expander_strobe_n_o(exp_n), .op_exec_i(opx), .opcode_i(opc), .next_pc_i(npc),
    .int_enable_i(inten), .count_sel_i(csel), .bus_latch_en_i(ble), .bus_latch_i(blat),
    .port2_drive_i(1'b0), .port2_latch_i(4'h0), .bus_req_i(req), .bus_take_o(take),
    .bus_rsp_o(rsp), .resume_o(res), .core_run_o(run), .osc_en_o(osc), .irq_start_o(irq),
    .test0_o(t0s), .test1_o(t1s), .count_pulse_o(cntp), .rom_addr_o(rom_a), .rom_data_i(rom_d)
  );
  mpmc_ext_mem u_mpmc_ext_mem (
    .clk_i(clk), .ale_i(ale), .pstrb_n_i(pstrb_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .bus_i(dbo), .bus_o(mem_bus)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_res(input logic [11:0] a, input int lo, input int hi);
    int n;
    n = 0;
    while (res.valid !== 1'b1 && n < hi) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n >= lo && n < hi), 16'h1);
    chk(16'(res.addr), 16'(a));
  endtask

  // Strobe vector is {program, read, write, expander}, all active low.
  task automatic bus_op(input mpmc_bus_kind_t k, input logic [11:0] a, input logic [7:0] wd,
                        input logic [3:0] strb, input logic [7:0] exp, input logic [7:0] msk);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{valid: 1'b1, kind: k, addr: a, wdata: wd};
    do begin
      @(negedge clk);
      n++;
    end while (take !== 1'b1 && n < 20);
    @(posedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
    chk(16'(ale), 16'h1);
    repeat (2) @(negedge clk);
    chk(16'({pstrb_n, rd_n, wr_n, exp_n}), 16'(strb));
    if (strb == 4'b0111) chk(16'(p2o), 16'(a[11:8]));
    repeat (2) @(negedge clk);
    chk(16'({rsp.done, rsp.rdata & msk}), 16'({1'b1, exp & msk}));
  endtask

  task automatic exec(input logic [7:0] op);
    @(posedge clk);
    opx <= 1'b1;
    opc <= op;
    @(posedge clk);
    opx <= 1'b0;
  endtask

  // The fetch's machine cycle ends in the single step pause, which holds the address strobe.
  task automatic step_one;
    @(posedge clk);
    sstep_n <= 1'b0;
    bus_op(MPMC_BK_FETCH, 12'h1c4, 8'h00, 4'b1111, 8'hc5, 8'hff);
    @(negedge clk);
    chk(16'({run, ale}), 16'h1);
    @(posedge clk);
    sstep_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(run), 16'h1);
  endtask

  task automatic idle_wake(input logic en, input logic [11:0] a);
    inten <= en;
    exec(MPMC_OP_IDLE);
    cyc(3);
    @(negedge clk);
    chk(16'({run, osc, ale, rd_n}), 16'h5);
    @(posedge clk);
    int_n <= 1'b0;
    wait_res(a, 1, 4);
    chk(16'(irq), 16'(en));
    @(posedge clk);
    int_n <= 1'b1;
  endtask

  task automatic standby_wake;
    inten <= 1'b1;
    exec(MPMC_OP_STANDBY);
    cyc(3);
    @(negedge clk);
    chk(16'({run, osc}), 16'h0);
    @(posedge clk);
    int_n <= 1'b0;
    // Two to three machine cycles of five clocks follow the start-up count.
    wait_res(MPMC_VEC_INT, OSC + 12, OSC + 18);
    @(posedge clk);
    int_n <= 1'b1;
  endtask

  task automatic stop_cycle;
    @(posedge clk);
    rpin_n <= 1'b0;
    cyc(2);
    stop_n <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(16'({osc, run, ale, pstrb_n, rd_n, wr_n, exp_n}), 16'h0f);
    @(posedge clk);
    stop_n <= 1'b1;
    cyc(OSC);
    rpin_n <= 1'b1;
    wait_res(MPMC_VEC_RESET, 1, 4);
  endtask

  task automatic verify_rd(input logic [10:0] a);
    @(posedge clk);
    rpin_n <= 1'b0;
    vdrive <= 1'b1;
    vbus <= a[7:0];
    p2i <= {1'b0, a[10:8]};
    cyc(2);
    vlev <= 1'b1;
    cyc(3);
    rpin_n <= 1'b1;
    cyc(3);
    @(negedge clk);
    chk(16'(rom_a), 16'(a));
    chk(16'({dboe, dbo}), 16'({1'b1, rom_of(a)}));
    @(posedge clk);
    rpin_n <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(16'(dboe), 16'h0);
    @(posedge clk);
    vlev <= 1'b0;
    cyc(2);
    rpin_n <= 1'b1;
    vdrive <= 1'b0;
    p2i <= 4'h9;
    wait_res(MPMC_VEC_RESET, 1, 4);
  endtask

  task automatic pins;
    int n;
    logic tz;
    n = 0;
    @(posedge clk);
    tin0 <= 1'b1;
    tin1 <= 1'b1;
    csel <= 1'b1;
    ble <= 1'b1;
    blat <= 8'h3c;
    cyc(3);
    @(negedge clk);
    chk(16'({t0s, t1s, dboe, dbo}), 16'h73c);
    @(posedge clk);
    tin1 <= 1'b0;
    while (cntp !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 4), 16'h1);
    exec(MPMC_OP_CLKOUT);
    cyc(2);
    @(negedge clk);
    chk(16'(t0oe), 16'h1);
    tz = t0o;
    @(negedge clk);
    chk(16'(t0o), 16'(!tz));
    @(posedge clk);
    ble <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 4000);
    errors++;
    wrap_up;
  end

  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    {rpin_n, stop_n, int_n, sstep_n} = 4'hf;
    {fext, vlev, tin0, tin1, opx, inten, csel, ble, vdrive} = '0;
    {opc, blat, vbus} = '0;
    npc = 12'h2b7;
    p2i = 4'h9;
    req = '0;
    cyc(10);
    rst <= 1'b0;
    wait_res(MPMC_VEC_RESET, 1, 4);
    bus_op(MPMC_BK_READ, 12'h012, 8'h00, 4'b1011, 8'hb7, 8'hff);
    bus_op(MPMC_BK_WRITE, 12'h034, 8'h5e, 4'b1101, 8'h00, 8'h00);
    bus_op(MPMC_BK_READ, 12'h034, 8'h00, 4'b1011, 8'h5e, 8'hff);
    step_one;
    bus_op(MPMC_BK_FETCH, 12'h9a7, 8'h00, 4'b0111, 8'h02, 8'hff);
    bus_op(MPMC_BK_EXP, 12'h000, 8'h04, 4'b1110, 8'h09, 8'h0f);
    @(posedge clk);
    fext <= 1'b1;
    bus_op(MPMC_BK_FETCH, 12'h345, 8'h00, 4'b0111, 8'he0, 8'hff);
    @(posedge clk);
    fext <= 1'b0;
    idle_wake(1'b1, MPMC_VEC_INT);
    idle_wake(1'b0, 12'h2b7);
    standby_wake;
    stop_cycle;
    verify_rd(11'h5c3);
    verify_rd(11'h02e);
    pins;
    wrap_up;
  end
endmodule // mpmc_seq_bench
`default_nettype wire
